// ---- inc/ssw_defines.svh ----
// Timing constants and reset values for the supply supervisor watchdog
`ifndef SSW_DEFINES_SVH
`define SSW_DEFINES_SVH

// Clock rate in kHz, so that a time in ms times this gives cycles
`define SSW_CLK_KHZ 40000

// Reset stretch, nominal, in ms
`define SSW_RST_PULSE_MS 200
`define SSW_RST_PULSE_CYC (`SSW_RST_PULSE_MS * `SSW_CLK_KHZ)

// Watchdog timeout, nominal, in ms
`define SSW_WD_TIMEOUT_MS 1600
`define SSW_WD_TIMEOUT_CYC (`SSW_WD_TIMEOUT_MS * `SSW_CLK_KHZ)

// Least extra stretch after a brownout, in ms
`define SSW_BROWNOUT_MS 100
`define SSW_BROWNOUT_CYC (`SSW_BROWNOUT_MS * `SSW_CLK_KHZ)

// Synchroniser width and bit positions
`define SSW_SYNC_W 5
`define SSW_BIT_SUPPLY 0
`define SSW_BIT_MR 1
`define SSW_BIT_STROBE 2
`define SSW_BIT_TRI 3
`define SSW_BIT_PF 4

// Output and state values under reset
`define SSW_RST_N_RST 1'b0
`define SSW_WDO_N_RST 1'b1
`define SSW_PFO_N_RST 1'b1
`define SSW_SYNC_RST 5'h00

`endif

// ---- inc/ssw_pkg.sv ----
// Types shared by the supply supervisor watchdog
`default_nettype none

package ssw_pkg;

   typedef enum logic [1:0] {
      SSW_HOLD = 2'b00,
      SSW_STRETCH = 2'b01,
      SSW_RUN = 2'b10
   } ssw_rst_state_type;

endpackage : ssw_pkg

`default_nettype wire

// ---- src/ssw_sync.sv ----
// Two flip-flop synchroniser, one lane per bit
`default_nettype none

module ssw_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_lane
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               meta_ff[gi] <= RST_VAL[gi];
               sync_ff[gi] <= RST_VAL[gi];
            end else begin
               meta_ff[gi] <= async_i[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate

   assign sync_o = sync_ff;

endmodule : ssw_sync

`default_nettype wire

// ---- src/ssw_top.sv ----
// Supply supervisor core: stretched reset, watchdog and power-fail outputs
//
// Functional notes
// - Manual reset input low starts a reset pulse on the reset output.
// - Each reset pulse holds reset low for nominal 200 ms, within 100 to 350 ms.
// - Reset stays low for as long as the supply is below threshold.
// - Release waits one pulse time after the last of supply-good or manual-reset-high.
// - Watchdog timeout never drives the reset output directly.
// - Strobe steady for nominal 1.6 s drives the watchdog output low.
// - A three-stated or floating strobe disables the watchdog timeout.
// - Watchdog counter clears on reset, three-stated strobe and every strobe edge.
// - After a timeout the watchdog output stays low until the counter clears.
// - Watchdog output is low while supply is low, with no minimum width.
// - On supply recovery watchdog output rises at once unless a timeout is pending.
// - Power-fail output is low while its comparator reports below 1.2 V.
// - A dip during a running pulse extends it at least 100 ms past the dip.
`default_nettype none
`include "ssw_defines.svh"

module ssw_top #(
   parameter int unsigned RST_PULSE_CYC = `SSW_RST_PULSE_CYC,
   parameter int unsigned WD_TIMEOUT_CYC = `SSW_WD_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic supply_low_i,
   input wire logic manual_reset_n_i,
   input wire logic watchdog_strobe_in_i,
   input wire logic watchdog_strobe_tristate_i,
   input wire logic power_fail_sense_in_i,
   output logic reset_n_o,
   output logic watchdog_timeout_out_n_o,
   output logic power_fail_out_n_o
);

   localparam int unsigned RST_CW = $clog2(RST_PULSE_CYC + 1);
   localparam int unsigned WD_CW = $clog2(WD_TIMEOUT_CYC + 1);
   localparam logic [RST_CW-1:0] RST_LAST = RST_CW'(RST_PULSE_CYC - 1);
   localparam logic [WD_CW-1:0] WD_LAST = WD_CW'(WD_TIMEOUT_CYC - 1);

   // Synchronised pin levels
   logic [`SSW_SYNC_W-1:0] pins_async;
   logic [`SSW_SYNC_W-1:0] pins_sync;
   logic supply_s;
   logic mr_n_s;
   logic strobe_s;
   logic tri_s;
   logic pf_s;

   assign pins_async[`SSW_BIT_SUPPLY] = supply_low_i;
   assign pins_async[`SSW_BIT_MR] = manual_reset_n_i;
   assign pins_async[`SSW_BIT_STROBE] = watchdog_strobe_in_i;
   assign pins_async[`SSW_BIT_TRI] = watchdog_strobe_tristate_i;
   assign pins_async[`SSW_BIT_PF] = power_fail_sense_in_i;

   ssw_sync #(
      .WIDTH(`SSW_SYNC_W),
      .RST_VAL(`SSW_SYNC_RST)
   ) u_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .async_i(pins_async),
      .sync_o(pins_sync)
   );

   assign supply_s = pins_sync[`SSW_BIT_SUPPLY];
   assign mr_n_s = pins_sync[`SSW_BIT_MR];
   assign strobe_s = pins_sync[`SSW_BIT_STROBE];
   assign tri_s = pins_sync[`SSW_BIT_TRI];
   assign pf_s = pins_sync[`SSW_BIT_PF];

   // Reset stretch state
   ssw_pkg::ssw_rst_state_type state_ff;
   ssw_pkg::ssw_rst_state_type nxt_state;
   logic [RST_CW-1:0] rst_cnt_ff;
   logic [RST_CW-1:0] nxt_rst_cnt;
   logic reset_n_ff;
   logic nxt_reset_n;
   logic hold;

   // Hold comes only from the supply and the manual input
   assign hold = supply_s | ~mr_n_s;

   always_comb begin
      nxt_state = state_ff;
      nxt_rst_cnt = rst_cnt_ff;
      case (state_ff)
         ssw_pkg::SSW_HOLD: begin
            nxt_rst_cnt = '0;
            if (!hold) begin
               nxt_state = ssw_pkg::SSW_STRETCH;
            end
         end
         ssw_pkg::SSW_STRETCH: begin
            if (hold) begin
               // A dip restarts the full stretch
               nxt_state = ssw_pkg::SSW_HOLD;
               nxt_rst_cnt = '0;
            end else if (rst_cnt_ff == RST_LAST) begin
               nxt_state = ssw_pkg::SSW_RUN;
               nxt_rst_cnt = '0;
            end else begin
               nxt_rst_cnt = rst_cnt_ff + RST_CW'(1);
            end
         end
         ssw_pkg::SSW_RUN: begin
            nxt_rst_cnt = '0;
            if (hold) begin
               nxt_state = ssw_pkg::SSW_HOLD;
            end
         end
         default: begin
            nxt_state = ssw_pkg::SSW_HOLD;
            nxt_rst_cnt = '0;
         end
      endcase
      nxt_reset_n = (nxt_state == ssw_pkg::SSW_RUN);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_ff <= ssw_pkg::SSW_HOLD;
         rst_cnt_ff <= '0;
         reset_n_ff <= `SSW_RST_N_RST;
      end else begin
         state_ff <= nxt_state;
         rst_cnt_ff <= nxt_rst_cnt;
         reset_n_ff <= nxt_reset_n;
      end
   end

   // Watchdog timer
   logic strobe_d_ff;
   logic nxt_strobe_d;
   logic [WD_CW-1:0] wd_cnt_ff;
   logic [WD_CW-1:0] nxt_wd_cnt;
   logic wd_to_ff;
   logic nxt_wd_to;
   logic wdo_n_ff;
   logic nxt_wdo_n;
   logic strobe_edge;
   logic wd_clr;

   assign strobe_edge = strobe_s ^ strobe_d_ff;
   assign wd_clr = ~reset_n_ff | tri_s | strobe_edge;

   always_comb begin
      nxt_strobe_d = strobe_s;
      nxt_wd_cnt = wd_cnt_ff;
      if (wd_clr) begin
         nxt_wd_cnt = '0;
      end else if (wd_cnt_ff != WD_LAST) begin
         nxt_wd_cnt = wd_cnt_ff + WD_CW'(1);
      end
      nxt_wd_to = ~wd_clr & (wd_to_ff | (wd_cnt_ff == WD_LAST));
      nxt_wdo_n = ~(supply_s | nxt_wd_to);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         strobe_d_ff <= 1'b0;
         wd_cnt_ff <= '0;
         wd_to_ff <= 1'b0;
         wdo_n_ff <= `SSW_WDO_N_RST;
      end else begin
         strobe_d_ff <= nxt_strobe_d;
         wd_cnt_ff <= nxt_wd_cnt;
         wd_to_ff <= nxt_wd_to;
         wdo_n_ff <= nxt_wdo_n;
      end
   end

   // Power-fail output
   logic pfo_n_ff;
   logic nxt_pfo_n;

   always_comb begin
      nxt_pfo_n = ~pf_s;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pfo_n_ff <= `SSW_PFO_N_RST;
      end else begin
         pfo_n_ff <= nxt_pfo_n;
      end
   end

   assign reset_n_o = reset_n_ff;
   assign watchdog_timeout_out_n_o = wdo_n_ff;
   assign power_fail_out_n_o = pfo_n_ff;

   // Checks
   property p_mr_reset;
      @(posedge clk_i) disable iff (srst_i)
      !mr_n_s |=> !reset_n_ff && (rst_cnt_ff == '0);
   endproperty
   a_mr_reset: assert property (p_mr_reset) else $error("Manual reset did not pull reset");

   property p_release_count;
      @(posedge clk_i) disable iff (srst_i)
      $rose(reset_n_ff) |-> $past(rst_cnt_ff) == RST_LAST;
   endproperty
   a_release_count: assert property (p_release_count) else $error("Reset released early");

   property p_supply_hold;
      @(posedge clk_i) disable iff (srst_i)
      supply_s [*2] |-> !reset_n_ff;
   endproperty
   a_supply_hold: assert property (p_supply_hold) else $error("Reset high with supply low");

   property p_release_after_hold;
      @(posedge clk_i) disable iff (srst_i)
      $rose(reset_n_ff) |-> !$past(hold) && (state_ff == ssw_pkg::SSW_RUN);
   endproperty
   a_release_after_hold: assert property (p_release_after_hold) else $error("Bad release");

   property p_no_wd_reset;
      @(posedge clk_i) disable iff (srst_i)
      reset_n_ff && !hold |=> reset_n_ff;
   endproperty
   a_no_wd_reset: assert property (p_no_wd_reset) else $error("Reset fell without cause");

   property p_timeout;
      @(posedge clk_i) disable iff (srst_i)
      (wd_cnt_ff == WD_LAST) && !wd_clr |=> wd_to_ff && !wdo_n_ff;
   endproperty
   a_timeout: assert property (p_timeout) else $error("Watchdog timeout missed");

   property p_tristate;
      @(posedge clk_i) disable iff (srst_i)
      tri_s |=> (wd_cnt_ff == '0) && !wd_to_ff;
   endproperty
   a_tristate: assert property (p_tristate) else $error("Watchdog ran while disabled");

   property p_edge_clear;
      @(posedge clk_i) disable iff (srst_i)
      (strobe_edge || !reset_n_ff) |=> (wd_cnt_ff == '0) && !wd_to_ff;
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("Watchdog not cleared");

   property p_timeout_sticky;
      @(posedge clk_i) disable iff (srst_i)
      wd_to_ff && !wd_clr |=> wd_to_ff && !wdo_n_ff;
   endproperty
   a_timeout_sticky: assert property (p_timeout_sticky) else $error("Timeout dropped");

   property p_wdo_lowline;
      @(posedge clk_i) disable iff (srst_i)
      supply_s |=> !wdo_n_ff;
   endproperty
   a_wdo_lowline: assert property (p_wdo_lowline) else $error("Watchdog high on low supply");

   property p_wdo_recover;
      @(posedge clk_i) disable iff (srst_i)
      $fell(supply_s) |-> ##1 (wdo_n_ff == !wd_to_ff);
   endproperty
   a_wdo_recover: assert property (p_wdo_recover) else $error("Watchdog output late");

   property p_pfo;
      @(posedge clk_i) disable iff (srst_i)
      ##1 (pfo_n_ff == !$past(pf_s));
   endproperty
   a_pfo: assert property (p_pfo) else $error("Power-fail output wrong");

   property p_dip_restart;
      @(posedge clk_i) disable iff (srst_i)
      (state_ff == ssw_pkg::SSW_STRETCH) && hold |=> !reset_n_ff && (rst_cnt_ff == '0);
   endproperty
   a_dip_restart: assert property (p_dip_restart) else $error("Dip did not restart");

endmodule : ssw_top

`default_nettype wire

// ---- dv/ssw_host_model.sv ----
// Host model that strobes the watchdog input
`default_nettype none

module ssw_host_model #(
   parameter int unsigned HALF = 8
) (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic float_i,
   output logic strobe_o,
   output logic tristate_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cnt_ff = 0;
   logic strobe_ff = 1'b0;
   assign strobe_o = strobe_ff;
   assign tristate_o = float_i;
   always @(posedge clk_i) begin
      cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
      // Floating strobe stays steady, so only the tristate sense stops the timeout
      if (run_i && !float_i && cnt_ff == HALF - 1) begin
         strobe_ff <= ~strobe_ff;
      end
   end
endmodule : ssw_host_model

`default_nettype wire

// ---- dv/ssw_top_tb.sv ----
// Self-checking bench for the supply supervisor core
`default_nettype none

module ssw_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned PULSE = 20;
   localparam int unsigned WDT = 50;
   localparam int unsigned HALF = 8;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic supply_low_i = 1'b0;
   logic mr_n = 1'b1;
   logic pf_i = 1'b0;
   logic run = 1'b0;
   logic flt = 1'b0;
   logic strobe;
   logic tri_s;
   logic rst_n;
   logic wdo_n;
   logic pfo_n;
   int fail_count = 0;
   int samples_checked = 0;
   int n;
   // Rows of power-fail input and expected output
   logic [1:0] rows [4] = '{2'b01, 2'b10, 2'b01, 2'b10};

   ssw_top #(.RST_PULSE_CYC(PULSE), .WD_TIMEOUT_CYC(WDT)) i_dut (
      .clk_i(clk_i), .srst_i(srst_i), .supply_low_i(supply_low_i),
      .manual_reset_n_i(mr_n), .watchdog_strobe_in_i(strobe),
      .watchdog_strobe_tristate_i(tri_s), .power_fail_sense_in_i(pf_i),
      .reset_n_o(rst_n), .watchdog_timeout_out_n_o(wdo_n), .power_fail_out_n_o(pfo_n));

   ssw_host_model #(.HALF(HALF)) i_host (
      .clk_i(clk_i), .run_i(run), .float_i(flt), .strobe_o(strobe), .tristate_o(tri_s));

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic stop_test();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask : check

   task automatic range(input string what, input int lo, input int hi, input int got);
      samples_checked++;
      if (got < lo || got > hi) begin
         fail_count++;
         $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
      end
   endtask : range

   // Counts edges until the chosen output shows the level
   task automatic wait_for(input string what, input bit wd, input logic lvl, input int lim,
                           output int cyc);
      cyc = 0;
      while ((wd ? wdo_n : rst_n) !== lvl) begin
         @(posedge clk_i);
         #1;
         cyc++;
         if (cyc > lim) begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, lvl, wd ? wdo_n : rst_n);
            stop_test();
         end
      end
   endtask : wait_for

   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      wait_for("power-up release", 0, 1'b1, PULSE + 10, n);
      range("power-up stretch", PULSE, PULSE + 6, n);
      wait_for("timeout", 1, 1'b0, WDT + 10, n);
      range("timeout time", WDT - 2, WDT + 4, n);
      repeat (WDT) @(posedge clk_i);
      #1 check("wdo held", 1'b0, wdo_n);
      check("reset untouched", 1'b1, rst_n);
      @(posedge clk_i);
      run <= 1'b1;
      wait_for("wdo cleared", 1, 1'b1, 2 * HALF + 8, n);
      repeat (3 * WDT) @(posedge clk_i);
      #1 check("wdo with strobes", 1'b1, wdo_n);
      @(posedge clk_i);
      run <= 1'b0;
      flt <= 1'b1;
      repeat (3 * WDT) @(posedge clk_i);
      #1 check("wdo floating", 1'b1, wdo_n);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         pf_i <= rows[i][1];
         repeat (4) @(posedge clk_i);
         #1 check("pfo", rows[i][0], pfo_n);
      end
      @(posedge clk_i);
      mr_n <= 1'b0;
      wait_for("mr assert", 0, 1'b0, 5, n);
      repeat (2 * PULSE) @(posedge clk_i);
      #1 check("reset under mr", 1'b0, rst_n);
      @(posedge clk_i);
      mr_n <= 1'b1;
      wait_for("mr release", 0, 1'b1, PULSE + 10, n);
      range("mr stretch", PULSE, PULSE + 6, n);
      @(posedge clk_i);
      supply_low_i <= 1'b1;
      wait_for("wdo low supply", 1, 1'b0, 5, n);
      repeat (2) @(posedge clk_i);
      #1 check("reset low supply", 1'b0, rst_n);
      @(posedge clk_i);
      supply_low_i <= 1'b0;
      wait_for("wdo recovery", 1, 1'b1, 5, n);
      check("reset still low", 1'b0, rst_n);
      repeat (PULSE / 2) @(posedge clk_i);
      supply_low_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      supply_low_i <= 1'b0;
      wait_for("brownout release", 0, 1'b1, PULSE + 10, n);
      range("brownout stretch", PULSE / 2, PULSE + 6, n);
      stop_test();
   end
endmodule : ssw_top_tb

`default_nettype wire
